// [verilog/pmwb_pkg.sv]
// constants for the configuration-space memory window base registers
package pmwb_pkg;
  // ==========================================================
  // register offsets in configuration space
  localparam logic [7:0] EXT_WINDOW_OFFSET = 8'h14;
  localparam logic [7:0] CARD_INFO_OFFSET = 8'h18;
  // ==========================================================
  // field positions: lowest writable pointer bit
  localparam int EXT_PTR_LSB = 14;
  localparam int CARD_PTR_LSB = 11;
  // ==========================================================
  // values after reset and for reads of unmapped offsets
  localparam logic [31:0] EXT_WINDOW_RESET = 32'h0000_0000;
  localparam logic [31:0] CARD_INFO_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // ==========================================================
  // strap capture: cycles after reset release before sampling
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // ==========================================================
  // strap capture phases, one-hot
  typedef enum logic [1:0] {
    PMWB_WAIT = 2'b01,
    PMWB_DONE = 2'b10
  } pmwb_phase_t;
endpackage : pmwb_pkg

// [verilog/pmwb_strap_sample.sv]
// captures the active-low card-mode strap once after reset release
`timescale 1ns/1ns
`default_nettype none
module pmwb_strap_sample (
  input wire logic mclk,
  input wire logic reset,
  input wire logic card_mode_strap_n,
  output logic card_info_enabled,
  output logic strap_sampled
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [1:0] cnt;
    pmwb_pkg::pmwb_phase_t phase;
    logic card_en;
  } pmwb_strap_t;

  pmwb_strap_t st_r;
  pmwb_strap_t st_nxt;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = card_mode_strap_n;
    st_nxt.sync2 = st_r.sync1;
    unique case (st_r.phase)
      pmwb_pkg::PMWB_WAIT: begin
        if (st_r.cnt == pmwb_pkg::STRAP_SETTLE) begin
          // strap low selects the card information window
          st_nxt.card_en = ~st_r.sync2;
          st_nxt.phase = pmwb_pkg::PMWB_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt + 2'h1;
        end
      end
      pmwb_pkg::PMWB_DONE: begin
        st_nxt.cnt = st_r.cnt;
      end
      default: begin
        st_nxt.phase = pmwb_pkg::PMWB_WAIT;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{sync1: 1'b1, sync2: 1'b1, cnt: 2'h0,
                phase: pmwb_pkg::PMWB_WAIT, card_en: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign card_info_enabled = st_r.card_en;
  assign strap_sampled = (st_r.phase == pmwb_pkg::PMWB_DONE);
endmodule : pmwb_strap_sample
`default_nettype wire

// [verilog/pmwb_bar_reg.sv]
// one memory base register with a writable pointer from bit PTR_LSB upward
`timescale 1ns/1ns
`default_nettype none
module pmwb_bar_reg #(
  parameter int PTR_LSB = 14,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic wr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] value
);
  typedef struct packed {
    logic [31-PTR_LSB:0] ptr;
  } pmwb_bar_t;

  pmwb_bar_t st_r;
  pmwb_bar_t st_nxt;
  logic [31:0] merged;

  // ==========================================================
  // byte-lane merge; only pointer bits are stored
  // read-only bits never stored
  always_comb begin
    st_nxt = st_r;
    merged = {st_r.ptr, {PTR_LSB{1'b0}}};
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merged[8*i +: 8] = wdata[8*i +: 8];
      end
    end
    if (wr && enable) begin
      st_nxt.ptr = merged[31:PTR_LSB];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{ptr: RESET_VALUE[31:PTR_LSB]};
    end else begin
      st_r <= st_nxt;
    end
  end

  // low bits are constant zero; disabled register reads zero
  // size fields read zero
  assign value = enable ? {st_r.ptr, {PTR_LSB{1'b0}}} : 32'h0000_0000;
endmodule : pmwb_bar_reg
`default_nettype wire

// [verilog/pmwb_windows.sv]
// configuration-space slave for the two memory window base registers
`timescale 1ns/1ns
`default_nettype none
module pmwb_windows (
  input wire logic mclk,
  input wire logic reset,
  input wire logic card_mode_strap_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic cfg_hit,
  output logic [31:0] ext_window_base,
  output logic [31:0] card_info_window_base,
  output logic card_info_enabled
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic hit;
  } pmwb_slave_t;

  pmwb_slave_t st_r;
  pmwb_slave_t st_nxt;
  logic ext_sel;
  logic card_sel;
  logic strap_sampled;
  logic [31:0] ext_value;
  logic [31:0] card_value;

  // ==========================================================
  // address decode
  function automatic logic addr_match(input logic [7:0] addr,
                                      input logic [7:0] offset);
    addr_match = (addr[7:2] == offset[7:2]);
  endfunction : addr_match

  assign ext_sel = addr_match(cfg_addr, pmwb_pkg::EXT_WINDOW_OFFSET);
  assign card_sel = addr_match(cfg_addr, pmwb_pkg::CARD_INFO_OFFSET);

  // ==========================================================
  // strap capture after reset
  // strap sampled once
  pmwb_strap_sample u_strap (
    .mclk(mclk),
    .reset(reset),
    .card_mode_strap_n(card_mode_strap_n),
    .card_info_enabled(card_info_enabled),
    .strap_sampled(strap_sampled)
  );

  // ==========================================================
  // base registers
  // extension pointer storage
  pmwb_bar_reg #(
    .PTR_LSB(pmwb_pkg::EXT_PTR_LSB),
    .RESET_VALUE(pmwb_pkg::EXT_WINDOW_RESET)
  ) u_ext (
    .mclk(mclk),
    .reset(reset),
    .enable(1'b1),
    .wr(cfg_wr && ext_sel),
    .be(cfg_be),
    .wdata(cfg_wdata),
    .value(ext_value)
  );

  pmwb_bar_reg #(
    .PTR_LSB(pmwb_pkg::CARD_PTR_LSB),
    .RESET_VALUE(pmwb_pkg::CARD_INFO_RESET)
  ) u_card (
    .mclk(mclk),
    .reset(reset),
    .enable(card_info_enabled),
    .wr(cfg_wr && card_sel),
    .be(cfg_be),
    .wdata(cfg_wdata),
    .value(card_value)
  );

  // ==========================================================
  // read path and acknowledge
  // readback is the selected register's stored pointer; unmapped offsets read UNMAPPED_READ
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = cfg_rd || cfg_wr;
    st_nxt.hit = (cfg_rd || cfg_wr) && (ext_sel || card_sel);
    if (cfg_rd) begin
      if (ext_sel) begin
        st_nxt.rdata = ext_value;
      end else if (card_sel) begin
        st_nxt.rdata = card_value;
      end else begin
        st_nxt.rdata = pmwb_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{rdata: 32'h0000_0000, ack: 1'b0, hit: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata = st_r.rdata;
  assign cfg_ack = st_r.ack;
  assign cfg_hit = st_r.hit;
  assign ext_window_base = ext_value;
  assign card_info_window_base = card_value;

  // ==========================================================
  // assertions
  a_ext_sizing: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_wr && ext_sel && cfg_be == 4'hF && cfg_wdata == 32'hFFFF_FFFF)
    |=> ext_value == 32'hFFFF_C000)
    else $error("extension sizing readback wrong");

  a_ext_store: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_wr && ext_sel && cfg_be == 4'hF)
    |=> ext_value[31:14] == $past(cfg_wdata[31:14]))
    else $error("extension pointer not stored");

  a_ext_hold: assert property (
    @(posedge mclk) disable iff (reset)
    !(cfg_wr && ext_sel) |=> $stable(ext_value))
    else $error("extension pointer changed without write");

  a_ext_size_zero: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel |=> cfg_rdata[13:4] == 10'h000)
    else $error("extension size field not zero");

  a_ext_prefetch: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel |=> !cfg_rdata[3])
    else $error("extension prefetch bit set");

  a_ext_memtype: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel |=> cfg_rdata[2:1] == 2'h0)
    else $error("extension memory type not zero");

  a_ext_mem_bit: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel |=> !cfg_rdata[0])
    else $error("extension memory indicator set");

  a_ext_readback: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel |=> cfg_rdata == $past(ext_value))
    else $error("extension readback differs from register");

  a_ext_bytelane: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_wr && ext_sel && cfg_be == 4'h8)
    |=> ext_value[31:24] == $past(cfg_wdata[31:24])
        && ext_value[23:14] == $past(ext_value[23:14]))
    else $error("extension byte lane merge wrong");

  // ==========================================================
  // card register checks
  a_card_disabled: assert property (
    @(posedge mclk) disable iff (reset)
    (strap_sampled && !card_info_enabled && cfg_rd && card_sel)
    |=> cfg_rdata == 32'h0000_0000)
    else $error("card register nonzero while disabled");

  a_card_store: assert property (
    @(posedge mclk) disable iff (reset)
    (card_info_enabled && cfg_wr && card_sel && cfg_be == 4'hF)
    |=> card_value[31:11] == $past(cfg_wdata[31:11]))
    else $error("card pointer not stored");

  a_card_size_zero: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && card_sel |=> cfg_rdata[10:4] == 7'h00)
    else $error("card size field not zero");

  a_card_low_bits: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && card_sel |=> cfg_rdata[3:1] == 3'h0)
    else $error("card prefetch or type bits set");

  a_card_mem_bit: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && card_sel |=> !cfg_rdata[0])
    else $error("card memory indicator set");

  a_card_readback: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && card_sel |=> cfg_rdata == $past(card_value))
    else $error("card readback differs from register");

  a_card_hold: assert property (
    @(posedge mclk) disable iff (reset)
    !(cfg_wr && card_sel) |=> $stable(card_value))
    else $error("card pointer changed without write");

  a_card_off_zero: assert property (
    @(posedge mclk) disable iff (reset)
    !card_info_enabled |-> card_value == 32'h0000_0000)
    else $error("card base nonzero while disabled");

  a_card_bytelane: assert property (
    @(posedge mclk) disable iff (reset)
    (card_info_enabled && cfg_wr && card_sel && cfg_be == 4'h3)
    |=> card_value[31:16] == $past(card_value[31:16])
        && card_value[15:11] == $past(cfg_wdata[15:11]))
    else $error("card byte lane merge wrong");

  a_card_sizing: assert property (
    @(posedge mclk) disable iff (reset)
    (card_info_enabled && cfg_wr && card_sel && cfg_be == 4'hF
     && cfg_wdata == 32'hFFFF_FFFF) |=> card_value == 32'hFFFF_F800)
    else $error("card sizing readback wrong");

  a_strap_capture: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(strap_sampled)
    |-> card_info_enabled == !$past(card_mode_strap_n, 3))
    else $error("strap captured wrong level");

  a_ro_ignored: assert property (
    @(posedge mclk) disable iff (reset)
    cfg_wr |=> ext_value[13:0] == 14'h0000
               && card_value[10:0] == 11'h000)
    else $error("read-only bits took written data");

  a_strap_freeze: assert property (
    @(posedge mclk) disable iff (reset)
    strap_sampled |=> strap_sampled && $stable(card_info_enabled))
    else $error("strap result changed after capture");

  // ==========================================================
  // port protocol checks
  a_ack_timing: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd || cfg_wr)
    |=> cfg_ack ##1 (!cfg_ack || $past(cfg_rd || cfg_wr)))
    else $error("acknowledge timing wrong");

  a_ack_on_access: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd || cfg_wr) |=> cfg_ack)
    else $error("access not acknowledged");

  a_ack_idle: assert property (
    @(posedge mclk) disable iff (reset)
    !(cfg_rd || cfg_wr) |=> !cfg_ack && !cfg_hit)
    else $error("acknowledge without access");

  a_hit_flag: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd || cfg_wr) |=> cfg_hit == $past(ext_sel || card_sel))
    else $error("hit flag wrong");

  a_unmapped_read: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd && !ext_sel && !card_sel)
    |=> cfg_rdata == pmwb_pkg::UNMAPPED_READ && !cfg_hit)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (
    @(posedge mclk) disable iff (reset)
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without read");

  // ==========================================================
  // scenario covers
  c_ext_sizing: cover property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && ext_sel ##1 cfg_rdata == 32'hFFFF_C000);

  c_card_write: cover property (
    @(posedge mclk) disable iff (reset)
    card_info_enabled && cfg_wr && card_sel && cfg_wdata != 32'h0);

  c_card_disabled_read: cover property (
    @(posedge mclk) disable iff (reset)
    strap_sampled && !card_info_enabled && cfg_rd && card_sel);

  c_unmapped: cover property (
    @(posedge mclk) disable iff (reset)
    cfg_rd && !ext_sel && !card_sel);

  c_strap_low: cover property (
    @(posedge mclk) disable iff (reset)
    $rose(strap_sampled) && card_info_enabled);
endmodule : pmwb_windows
`default_nettype wire

// [verif/pmwb_host.sv]
// host model issuing configuration reads and writes
`timescale 1ns/1ns
`default_nettype none
module pmwb_host (
  input wire logic mclk,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic cfg_hit,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  // ==========================================================
  // access task
  initial begin
    cfg_rd = 1'h0;
    cfg_wr = 1'h0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  task automatic access(input logic wr, input logic [7:0] addr,
      input logic [3:0] be, input logic [31:0] data,
      output logic [31:0] rdata, output logic ack, output logic hit);
    @(negedge mclk);
    cfg_rd = ~wr;
    cfg_wr = wr;
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = data;
    @(negedge mclk);
    rdata = cfg_rdata;
    ack = cfg_ack;
    hit = cfg_hit;
    cfg_rd = 1'h0;
    cfg_wr = 1'h0;
    // released lines show no stale value
    cfg_addr = ~addr;
    cfg_be = ~be;
    cfg_wdata = ~data;
  endtask : access
endmodule : pmwb_host
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the memory window base registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] EXT = pmwb_pkg::EXT_WINDOW_OFFSET;
  localparam logic [7:0] CARD = pmwb_pkg::CARD_INFO_OFFSET;
  logic mclk;
  logic reset;
  logic card_mode_strap_n;
  logic cfg_rd;
  logic cfg_wr;
  logic cfg_ack;
  logic cfg_hit;
  logic card_info_enabled;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic [31:0] ext_window_base;
  logic [31:0] card_info_window_base;
  logic [31:0] rd_val;
  logic ack_seen;
  logic hit_seen;
  int n_mismatch;
  int checks;
  int cycles;
  // ==========================================================
  // clock, design and host
  initial mclk = 1'h0;
  always #10 mclk = ~mclk;
  pmwb_windows uut (.mclk(mclk), .reset(reset),
    .card_mode_strap_n(card_mode_strap_n), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .cfg_hit(cfg_hit), .ext_window_base(ext_window_base),
    .card_info_window_base(card_info_window_base),
    .card_info_enabled(card_info_enabled));
  pmwb_host host (.mclk(mclk), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .cfg_hit(cfg_hit), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  // ==========================================================
  // checking and access tasks
  task automatic complete_run;
    $display("mismatches %0d of %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_flag(input string what, input logic exp,
      input logic got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
    host.access(1'h1, a, be, d, rd_val, ack_seen, hit_seen);
    chk_flag("write ack", 1'h1, ack_seen);
    chk_flag("write hit", 1'h1, hit_seen);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic exp_hit);
    host.access(1'h0, a, 4'h0, 32'h0000_0000, rd_val, ack_seen, hit_seen);
    chk_flag("read ack", 1'h1, ack_seen);
    chk_flag("read hit", exp_hit, hit_seen);
    chk("read data", exp, rd_val);
  endtask : rd
  task automatic do_reset(input logic strap_n);
    @(negedge mclk);
    reset = 1'h1;
    card_mode_strap_n = strap_n;
    repeat (20) @(negedge mclk);
    reset = 1'h0;
    repeat (5) @(negedge mclk);
  endtask : do_reset
  // ==========================================================
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    reset = 1'h1;
    card_mode_strap_n = 1'h1;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    do_reset(1'h1);
    chk_flag("card enabled", 1'h0, card_info_enabled);
    rd(EXT, 32'h0000_0000, 1'h1);
    wr(CARD, 4'hF, 32'hFFFF_FFFF);
    rd(CARD, 32'h0000_0000, 1'h1);
    chk("card base", 32'h0000_0000, card_info_window_base);
    wr(EXT, 4'hF, 32'hFFFF_FFFF);
    rd(EXT, 32'hFFFF_C000, 1'h1);
    chk("ext size", 32'h0000_0000, {22'h0, rd_val[13:4]});
    chk("ext prefetch", 32'h0000_0000, {31'h0, rd_val[3]});
    chk("ext type", 32'h0000_0000, {30'h0, rd_val[2:1]});
    chk("ext space", 32'h0000_0000, {31'h0, rd_val[0]});
    wr(EXT, 4'hF, 32'h1234_5678);
    rd(EXT, 32'h1234_4000, 1'h1);
    wr(EXT, 4'h8, 32'hAB00_0000);
    rd(EXT, 32'hAB34_4000, 1'h1);
    chk("ext base", 32'hAB34_4000, ext_window_base);
    rd(8'h1C, pmwb_pkg::UNMAPPED_READ, 1'h0);
    do_reset(1'h0);
    chk_flag("card enabled", 1'h1, card_info_enabled);
    rd(EXT, pmwb_pkg::EXT_WINDOW_RESET, 1'h1);
    rd(CARD, pmwb_pkg::CARD_INFO_RESET, 1'h1);
    wr(CARD, 4'hF, 32'hFFFF_FFFF);
    rd(CARD, 32'hFFFF_F800, 1'h1);
    chk("card size", 32'h0000_0000, {25'h0, rd_val[10:4]});
    chk("card pf type", 32'h0000_0000, {29'h0, rd_val[3:1]});
    chk("card space", 32'h0000_0000, {31'h0, rd_val[0]});
    wr(CARD, 4'h3, 32'h0000_5FFF);
    rd(CARD, 32'hFFFF_5800, 1'h1);
    chk("card base", 32'hFFFF_5800, card_info_window_base);
    complete_run;
  end
endmodule : testbench
`default_nettype wire
